// ### inc/stamper_pkg.sv
package stamper_pkg;
   // field enable bit positions, also the fixed order of appended words
   localparam int FLD_COUNT     = 6;
   localparam int FLD_FRAME     = 0;
   localparam int FLD_TIME      = 1;
   localparam int FLD_SHAFT     = 2;
   localparam int FLD_INPUTS    = 3;
   localparam int FLD_BURST     = 4;
   localparam int FLD_PAGE      = 5;
   localparam int DATA_W        = 32;
   localparam int FIFO_DEPTH    = 16;
   localparam int INPUT_W       = 8;
   localparam int PAGE_W        = 4;
   localparam int CNT_W         = 16;
   // clock and tick timing
   localparam int CLK_HZ        = 25_000_000;
   localparam int TICK_MS       = 1;
   localparam int TICK_1MS_CYC  = CLK_HZ / 1000 * TICK_MS;
   localparam int TICK_10US_CYC = CLK_HZ / 100_000;
   // supported exponents of the tick unit
   localparam logic signed [3:0] EXP_MS   = 4'shd; // -3
   localparam logic signed [3:0] EXP_100U = 4'shc; // -4
   localparam logic signed [3:0] EXP_10U  = 4'shb; // -5
   localparam logic signed [3:0] EXP_CS   = 4'she; // -2
   localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
   // output state machine
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01
   } emit_state_t;
endpackage : stamper_pkg

// ### rtl/meta_fifo.sv
`timescale 1ns/1ns
// synchronous fifo with valid/ready on both sides
module meta_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output      logic             in_ready,
   output      logic [WIDTH-1:0] out_data,
   output      logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      level_r;
   logic             push;
   logic             pop;

   // handshakes
   assign in_ready  = (level_r != (AW+1)'(DEPTH));
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         level_r  <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
         level_r <= level_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // registered head word: refilled whenever empty or consumed
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (!out_valid || out_ready) begin
         out_valid <= 1'b0;
         if (level_r != '0 && !(out_valid && level_r == 1)) begin
            out_valid <= 1'b1;
            out_data  <= mem_r[out_valid ? rd_ptr_r + 1'b1 : rd_ptr_r];
         end
      end
   end
endmodule : meta_fifo

// ### rtl/edge_trigger.sv
`timescale 1ns/1ns
// edge detector with ready gating and overrun counting
module edge_trigger (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        level_in,
   input  wire logic        on_fall,
   input  wire logic        ready,
   output      logic        accepted,
   output      logic [15:0] overrun_count
);
   logic prev_r;
   logic ready_r;
   logic edge_seen;

   // previous level and ready seen one cycle before the edge
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prev_r  <= 1'b0;
         ready_r <= 1'b0;
      end else begin
         prev_r  <= level_in;
         ready_r <= ready;
      end
   end

   assign edge_seen = on_fall ? (prev_r && !level_in) : (!prev_r && level_in);
   assign accepted  = edge_seen && ready_r;

   // ignored edges counted, saturating
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         overrun_count <= '0;
      end else if (edge_seen && !ready_r && overrun_count != 16'hffff) begin
         overrun_count <= overrun_count + 16'h0001;
      end
   end
endmodule : edge_trigger

// ### rtl/frame_metadata_stamper.sv
`timescale 1ns/1ns
// Overview of operation
// - a global enable and per-field enables decide which metadata words are sent.
// - the frame counter is a 16-bit unsigned count advancing once per acquired frame.
// - with burst trigger on, the frame counter clears at start and wraps after burst length.
// - with burst trigger off, the frame counter runs 0 to 65535 and wraps.
// - a 16-bit time counter advances per tick, default 1 ms, and clears at start.
// - the time field holds the time counter sampled at the frame-start event.
// - the tick period is a power of ten seconds chosen from a supported set, -3 is 1 ms.
// - the shaft field holds the 32-bit encoder position sampled at frame start.
// - the input field holds all input levels sampled at frame start.
// - with burst trigger on, a 16-bit burst counter counts accepted burst triggers.
// - the page field holds the sequencer page active at frame start.
// - a rising edge starts exposure and a falling edge ends it, each only if ready before.
// - in burst mode the device waits for a trigger, takes burst length frames, then waits.
// - a trigger arriving while not ready is ignored and counted in an overrun counter.
module frame_metadata_stamper
   import stamper_pkg::*;
(
   input  wire logic                             sys_clk,
   input  wire logic                             reset,
   input  wire logic                             acq_start,
   input  wire logic                             metadata_enable,
   input  wire logic [stamper_pkg::FLD_COUNT-1:0] field_enable,
   input  wire logic                             burst_mode,
   input  wire logic [15:0]                      frames_per_burst,
   input  wire logic signed [3:0]                tick_unit_exponent,
   input  wire logic                             burst_trig_in,
   input  wire logic                             expose_pin,
   input  wire logic [stamper_pkg::INPUT_W-1:0]  input_pins,
   input  wire logic [31:0]                      shaft_position,
   input  wire logic [stamper_pkg::PAGE_W-1:0]   active_page,
   input  wire logic                             frame_done,
   output      logic                             exposing,
   output      logic                             acquiring,
   output      logic                             frame_trig_ready,
   output      logic                             expo_end_trig_ready,
   output      logic                             burst_trig_ready,
   output      logic [15:0]                      frame_trig_overruns,
   output      logic [15:0]                      expo_end_overruns,
   output      logic [15:0]                      burst_trig_overruns,
   output      logic [stamper_pkg::DATA_W-1:0]   meta_data,
   output      logic                             meta_valid,
   output      logic                             meta_last,
   input  wire logic                             meta_ready
);
   import stamper_pkg::*;

   // pin synchronisers
   logic [INPUT_W+1:0] pin_s1_r;
   logic [INPUT_W+1:0] pin_s2_r;
   logic               burst_pin;
   logic               expo_pin;
   logic [INPUT_W-1:0] inputs_sync;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= {burst_trig_in, expose_pin, input_pins};
         pin_s2_r <= pin_s1_r;
      end
   end
   assign burst_pin   = pin_s2_r[INPUT_W+1];
   assign expo_pin    = pin_s2_r[INPUT_W];
   assign inputs_sync = pin_s2_r[INPUT_W-1:0];

   // trigger modules
   logic        frame_go;
   logic        expo_end;
   logic        burst_go;
   logic [15:0] burst_left_r;
   logic        frame_busy_r;
   logic        stamp_busy;

   assign burst_trig_ready    = burst_mode && (burst_left_r == '0) && !frame_busy_r;
   assign frame_trig_ready    = acquiring && !exposing && !frame_busy_r && !stamp_busy;
   assign expo_end_trig_ready = exposing;

   edge_trigger u_burst_trig (
      .sys_clk       (sys_clk),
      .reset         (reset),
      .level_in      (burst_pin),
      .on_fall       (1'b0),
      .ready         (burst_trig_ready),
      .accepted      (burst_go),
      .overrun_count (burst_trig_overruns)
   );

   edge_trigger u_frame_trig (
      .sys_clk       (sys_clk),
      .reset         (reset),
      .level_in      (expo_pin),
      .on_fall       (1'b0),
      .ready         (frame_trig_ready),
      .accepted      (frame_go),
      .overrun_count (frame_trig_overruns)
   );

   edge_trigger u_end_trig (
      .sys_clk       (sys_clk),
      .reset         (reset),
      .level_in      (expo_pin),
      .on_fall       (1'b1),
      .ready         (expo_end_trig_ready),
      .accepted      (expo_end),
      .overrun_count (expo_end_overruns)
   );

   // acquisition window: always open without burst mode, else frames left in the burst
   assign acquiring = burst_mode ? (burst_left_r != '0) : 1'b1;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         burst_left_r <= '0;
      end else if (acq_start || !burst_mode) begin
         burst_left_r <= '0;
      end else if (burst_go) begin
         burst_left_r <= frames_per_burst;
      end else if (frame_go && burst_left_r != '0) begin
         burst_left_r <= burst_left_r - 16'h0001;
      end
   end

   // exposure state, rising edge opens and falling edge closes
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         exposing <= 1'b0;
      end else if (frame_go) begin
         exposing <= 1'b1;
      end else if (expo_end) begin
         exposing <= 1'b0;
      end
   end

   // frame in flight until readout signals done
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         frame_busy_r <= 1'b0;
      end else if (frame_go) begin
         frame_busy_r <= 1'b1;
      end else if (frame_done) begin
         frame_busy_r <= 1'b0;
      end
   end

   // tick divider, period chosen by the exponent
   logic [31:0] tick_cnt_r;
   logic [31:0] tick_len;
   logic        tick;

   function automatic logic [31:0] tick_cycles(input logic signed [3:0] e);
      unique case (e)
         EXP_CS:   tick_cycles = 32'(TICK_1MS_CYC * 10);
         EXP_100U: tick_cycles = 32'(TICK_10US_CYC * 10);
         EXP_10U:  tick_cycles = 32'(TICK_10US_CYC);
         default:  tick_cycles = 32'(TICK_1MS_CYC);
      endcase
   endfunction : tick_cycles

   assign tick_len = tick_cycles(tick_unit_exponent);
   assign tick     = (tick_cnt_r >= tick_len - 32'd1);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tick_cnt_r <= '0;
      end else if (acq_start || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'd1;
      end
   end

   // time counter
   logic [CNT_W-1:0] time_r;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         time_r <= CNT_RST;
      end else if (acq_start) begin
         time_r <= CNT_RST;
      end else if (tick) begin
         time_r <= time_r + 16'h0001;
      end
   end

   // frame counter, value stamped is the count before advancing
   logic [CNT_W-1:0] frame_cnt_r;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         frame_cnt_r <= CNT_RST;
      end else if (acq_start && burst_mode) begin
         frame_cnt_r <= CNT_RST;
      end else if (frame_go) begin
         if (burst_mode && frame_cnt_r >= frames_per_burst - 16'h0001) begin
            frame_cnt_r <= CNT_RST;
         end else begin
            frame_cnt_r <= frame_cnt_r + 16'h0001;
         end
      end
   end

   // burst counter
   logic [CNT_W-1:0] burst_cnt_r;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         burst_cnt_r <= CNT_RST;
      end else if (acq_start) begin
         burst_cnt_r <= CNT_RST;
      end else if (burst_go && burst_mode) begin
         burst_cnt_r <= burst_cnt_r + 16'h0001;
      end
   end

   // snapshot taken at the frame-start event
   logic [DATA_W-1:0] snap_r [FLD_COUNT];
   logic [FLD_COUNT-1:0] sel_r;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < FLD_COUNT; i++) snap_r[i] <= '0;
         sel_r <= '0;
      end else if (frame_go) begin
         snap_r[FLD_FRAME]  <= {16'h0000, frame_cnt_r};
         snap_r[FLD_TIME]   <= {16'h0000, time_r};
         snap_r[FLD_SHAFT]  <= shaft_position;
         snap_r[FLD_INPUTS] <= {{(DATA_W-INPUT_W){1'b0}}, inputs_sync};
         snap_r[FLD_BURST]  <= {16'h0000, burst_cnt_r};
         snap_r[FLD_PAGE]   <= {{(DATA_W-PAGE_W){1'b0}}, active_page};
         sel_r <= metadata_enable ? field_enable : '0;
      end
   end

   // emitter walks the fields in fixed order into the fifo after frame done
   emit_state_t state_r;
   logic [2:0]  idx_r;
   logic [FLD_COUNT-1:0] pend_r;
   logic        f_valid;
   logic        f_ready;
   logic        f_last;
   logic [DATA_W:0] f_word;
   logic [DATA_W:0] q_word;

   assign stamp_busy = (state_r != ST_IDLE);
   assign f_valid    = (state_r == ST_SEND) && pend_r[idx_r];
   assign f_last     = ((pend_r >> idx_r) >> 1) == '0;
   assign f_word     = {f_last, snap_r[idx_r]};

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         idx_r   <= '0;
         pend_r  <= '0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (frame_busy_r && frame_done && sel_r != '0) begin
                  state_r <= ST_SEND;
                  idx_r   <= '0;
                  pend_r  <= sel_r;
               end
            end
            ST_SEND: begin
               if (!pend_r[idx_r] || f_ready) begin
                  if (pend_r[idx_r] && f_last) state_r <= ST_IDLE;
                  idx_r <= idx_r + 3'd1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   meta_fifo #(
      .WIDTH (DATA_W + 1),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .in_data   (f_word),
      .in_valid  (f_valid),
      .in_ready  (f_ready),
      .out_data  (q_word),
      .out_valid (meta_valid),
      .out_ready (meta_ready)
   );
   assign meta_data = q_word[DATA_W-1:0];
   assign meta_last = q_word[DATA_W];

   // helper for the overrun check: level and ready one cycle back
   logic prev_lvl_r;
   logic prev_rise_ok;
   logic expo_rise;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prev_lvl_r   <= 1'b0;
         prev_rise_ok <= 1'b0;
      end else begin
         prev_lvl_r   <= expo_pin;
         prev_rise_ok <= frame_trig_ready;
      end
   end
   assign expo_rise = expo_pin && !prev_lvl_r;

   // emission steps: a closed frame with fields chosen, then the walk from the first field
   sequence frame_closed_s;
      state_r == ST_IDLE && frame_busy_r && frame_done && sel_r != '0;
   endsequence
   sequence walk_begins_s;
      state_r == ST_SEND && idx_r == 3'd0 && pend_r == sel_r;
   endsequence

   // checks
   frame_cnt_wrap_a: assert property (@(posedge sys_clk) disable iff (reset)
      frame_go && !acq_start && burst_mode && frames_per_burst != 16'h0000
      && frame_cnt_r == frames_per_burst - 16'h0001 |=> frame_cnt_r == CNT_RST)
      else $error("frame count did not wrap at burst end");
   frame_cnt_free_a: assert property (@(posedge sys_clk) disable iff (reset)
      frame_go && !burst_mode |=> frame_cnt_r == $past(frame_cnt_r) + 16'h0001)
      else $error("free frame count did not advance");
   time_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      acq_start |=> time_r == CNT_RST)
      else $error("time counter not cleared at start");
   time_stamp_a: assert property (@(posedge sys_clk) disable iff (reset)
      frame_go |=> snap_r[FLD_TIME][15:0] == $past(time_r))
      else $error("time stamp not sampled at frame start");
   shaft_stamp_a: assert property (@(posedge sys_clk) disable iff (reset)
      frame_go |=> snap_r[FLD_SHAFT] == $past(shaft_position))
      else $error("shaft position not sampled");
   page_stamp_a: assert property (@(posedge sys_clk) disable iff (reset)
      frame_go |=> snap_r[FLD_PAGE][PAGE_W-1:0] == $past(active_page))
      else $error("page not sampled");
   burst_count_a: assert property (@(posedge sys_clk) disable iff (reset)
      burst_go && burst_mode && !acq_start |=> burst_cnt_r == $past(burst_cnt_r) + 16'h0001)
      else $error("burst count did not advance");
   expo_open_a: assert property (@(posedge sys_clk) disable iff (reset)
      frame_go |=> exposing)
      else $error("exposure did not start");
   overrun_count_a: assert property (@(posedge sys_clk) disable iff (reset)
      !prev_rise_ok && expo_rise && frame_trig_overruns != 16'hffff
      |=> frame_trig_overruns == $past(frame_trig_overruns) + 16'h0001)
      else $error("ignored trigger not counted");
   disabled_silent_a: assert property (@(posedge sys_clk) disable iff (reset)
      frame_go && !metadata_enable |=> sel_r == '0)
      else $error("fields selected while disabled");
   emit_start_a: assert property (@(posedge sys_clk) disable iff (reset)
      frame_closed_s |=> walk_begins_s)
      else $error("field emission did not start");
endmodule : frame_metadata_stamper

// ### verification/meta_sink.sv
`timescale 1ns/1ns
// host side of the metadata stream: may stall, and records {last, data}
module meta_sink
   import stamper_pkg::*;
(
   input  wire logic                           sys_clk,
   input  wire logic                           reset,
   input  wire logic                           hold,
   input  wire logic                           slow,
   input  wire logic [stamper_pkg::DATA_W-1:0] meta_data,
   input  wire logic                           meta_valid,
   input  wire logic                           meta_last,
   output      logic                           meta_ready
);
   logic [DATA_W:0] got[$];
   logic            phase_r;

   // ready changes just after an edge; slow mode takes every other cycle
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         meta_ready <= 1'b0;
         phase_r    <= 1'b0;
      end else begin
         phase_r    <= ~phase_r;
         meta_ready <= !hold && (!slow || phase_r);
      end
   end

   // a word is taken at the edge where valid and ready are both high
   always @(posedge sys_clk) begin
      if (!reset && meta_valid === 1'b1 && meta_ready) begin
         got.push_back({meta_last, meta_data});
      end
   end
endmodule : meta_sink

// ### verification/frame_metadata_stamper_tb_top.sv
`timescale 1ns/1ns
module frame_metadata_stamper_tb_top;
   import stamper_pkg::*;
   typedef struct {
      logic me; logic [5:0] fe; logic [31:0] sh; logic [7:0] ip; logic [3:0] pg; logic slow;
   } row_t;
   logic sys_clk = 1'b0, reset = 1'b1, acq_start = 1'b0, metadata_enable = 1'b1;
   logic burst_mode = 1'b0, burst_trig_in = 1'b0, expose_pin = 1'b0, frame_done = 1'b0;
   logic hold = 1'b0, slow = 1'b0;
   logic [FLD_COUNT-1:0] field_enable       = '0;
   logic [15:0]          frames_per_burst   = 16'h0004;
   logic signed [3:0]    tick_unit_exponent = EXP_MS;
   logic [INPUT_W-1:0]   input_pins         = '0;
   logic [31:0]          shaft_position     = '0;
   logic [PAGE_W-1:0]    active_page        = '0;
   logic exposing, acquiring, frame_trig_ready, expo_end_trig_ready, burst_trig_ready;
   logic meta_valid, meta_last, meta_ready;
   logic [15:0]          frame_trig_overruns, expo_end_overruns, burst_trig_overruns;
   logic [DATA_W-1:0]    meta_data;
   logic [DATA_W:0]      exp_q[$];
   int                   checks = 0, n_mismatch = 0, fcnt = 0, ovr_want = 0;
   logic signed [3:0]    exps[4] = '{EXP_10U, EXP_100U, EXP_MS, EXP_CS};
   // cycles waited after start, and the time stamp that this wait must give
   int                   per[4]  = '{TICK_10US_CYC * 5 / 2, TICK_10US_CYC * 25,
                                     TICK_1MS_CYC * 3 / 2, TICK_1MS_CYC * 3 / 2};
   int                   tsw[4]  = '{2, 2, 1, 0};
   row_t rows[5] = '{'{1'b1, 6'h3d, 32'hdeadbeef, 8'ha5, 4'h9, 1'b0},
                     '{1'b1, 6'h01, 32'h0, 8'h0, 4'h0, 1'b1},
                     '{1'b0, 6'h3f, 32'h1, 8'h1, 4'h1, 1'b0},
                     '{1'b1, 6'h24, 32'h8000_0001, 8'h5a, 4'hf, 1'b1},
                     '{1'b1, 6'h18, 32'h7, 8'hff, 4'h3, 1'b0}};

   always #20 sys_clk = ~sys_clk;

   frame_metadata_stamper dut_u (
      .sys_clk, .reset, .acq_start, .metadata_enable, .field_enable, .burst_mode,
      .frames_per_burst, .tick_unit_exponent, .burst_trig_in, .expose_pin, .input_pins,
      .shaft_position, .active_page, .frame_done, .exposing, .acquiring, .frame_trig_ready,
      .expo_end_trig_ready, .burst_trig_ready, .frame_trig_overruns, .expo_end_overruns,
      .burst_trig_overruns, .meta_data, .meta_valid, .meta_last, .meta_ready);

   meta_sink sink_u (.sys_clk, .reset, .hold, .slow, .meta_data, .meta_valid, .meta_last,
                     .meta_ready);

   // compare one value, count it, report a difference
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("ERROR %0t seen %h want %h", $time, seen, want);
      end
   endtask : check

   // wait a bounded time for a level, then compare it
   task automatic wait_for(ref logic sig, input logic val);
      int n;
      n = 0;
      while (sig !== val && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      check(sig, val);
   endtask : wait_for

   task automatic pulse_start;
      acq_start = 1'b1;
      @(negedge sys_clk);
      acq_start = 1'b0;
   endtask : pulse_start

   // one frame on the exposure pin; optional stray edge before readout ends
   task automatic do_frame(input logic [31:0] sh, input logic [7:0] ip, input logic [3:0] pg,
                           input logic [15:0] tm, input logic [15:0] bn, input bit poke);
      logic [DATA_W-1:0] w[FLD_COUNT];
      int                lst;
      w   = '{32'(fcnt), 32'(tm), sh, 32'(ip), 32'(bn), 32'(pg)};
      lst = -1;
      shaft_position = sh;
      input_pins     = ip;
      active_page    = pg;
      wait_for(frame_trig_ready, 1'b1);
      expose_pin = 1'b1;
      wait_for(exposing, 1'b1);
      shaft_position = ~sh;
      input_pins     = ~ip;
      active_page    = ~pg;
      wait_for(expo_end_trig_ready, 1'b1);
      expose_pin = 1'b0;
      wait_for(exposing, 1'b0);
      if (poke) begin
         check(frame_trig_ready, 1'b0);
         expose_pin = 1'b1;
         repeat (6) @(negedge sys_clk);
         check(exposing, 1'b0);
         expose_pin = 1'b0;
         repeat (6) @(negedge sys_clk);
         ovr_want++;
         check(frame_trig_overruns, 16'(ovr_want));
         check(expo_end_overruns, 16'(ovr_want));
      end
      frame_done = 1'b1;
      @(negedge sys_clk);
      frame_done = 1'b0;
      for (int i = 0; i < FLD_COUNT; i++) begin
         if (metadata_enable && field_enable[i]) lst = i;
      end
      for (int i = 0; i < FLD_COUNT; i++) begin
         if (metadata_enable && field_enable[i]) exp_q.push_back({i == lst, w[i]});
      end
      fcnt = (burst_mode && fcnt == int'(frames_per_burst) - 1) ? 0 : (fcnt + 1) % 65536;
   endtask : do_frame

   // collect the host's words and compare them in order
   task automatic drain;
      int n;
      n = 0;
      while (sink_u.got.size() < exp_q.size() && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      repeat (8) @(negedge sys_clk);
      check(sink_u.got.size(), exp_q.size());
      foreach (exp_q[i]) begin
         if (i < sink_u.got.size()) check(sink_u.got[i], exp_q[i]);
      end
      sink_u.got.delete();
      exp_q.delete();
   endtask : drain

   task automatic stop_test;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   // watchdog a little beyond the longest expected run of about 84k cycles
   initial begin
      #3_700_000;
      n_mismatch++;
      stop_test();
   end

   initial begin
      repeat (2) @(negedge sys_clk);
      check(meta_valid, 1'b0);
      check(exposing, 1'b0);
      check(frame_trig_overruns, 16'h0000);
      check(acquiring, 1'b1);
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      repeat (3) @(negedge sys_clk);
      // table of field selections, frame counter runs freely
      foreach (rows[r]) begin
         metadata_enable = rows[r].me;
         field_enable    = rows[r].fe;
         slow            = rows[r].slow;
         do_frame(rows[r].sh, rows[r].ip, rows[r].pg, 16'h0, 16'h0, r == 1);
         drain();
      end
      // host stalls: three frames queue up, first word stays presented
      metadata_enable = 1'b1;
      field_enable    = 6'h3d;
      hold            = 1'b1;
      repeat (3) do_frame(32'h1234_5678, 8'h3c, 4'h6, 16'h0, 16'h0, 1'b0);
      check(meta_valid, 1'b1);
      check(meta_data, exp_q[0][DATA_W-1:0]);
      hold = 1'b0;
      slow = 1'b1;
      drain();
      // time stamp at each tick unit, cleared by acquisition start
      field_enable = 6'h02;
      foreach (exps[k]) begin
         tick_unit_exponent = exps[k];
         pulse_start();
         repeat (per[k]) @(negedge sys_clk);
         do_frame(32'h0, 8'h0, 4'h0, 16'(tsw[k]), 16'h0, 1'b0);
         drain();
      end
      // bursts of three frames, stray trigger while acquiring
      burst_mode       = 1'b1;
      frames_per_burst = 16'h0003;
      field_enable     = 6'h11;
      pulse_start();
      fcnt = 0;
      check(acquiring, 1'b0);
      for (int b = 1; b <= 2; b++) begin
         wait_for(burst_trig_ready, 1'b1);
         burst_trig_in = 1'b1;
         wait_for(acquiring, 1'b1);
         burst_trig_in = 1'b0;
         repeat (4) @(negedge sys_clk);
         burst_trig_in = 1'b1;
         repeat (6) @(negedge sys_clk);
         burst_trig_in = 1'b0;
         check(burst_trig_overruns, 16'(b));
         repeat (3) do_frame(32'h0, 8'h0, 4'h0, 16'h0, 16'(b), 1'b0);
         wait_for(acquiring, 1'b0);
         drain();
      end
      // reset in mid-run: counters and exposure go back to idle
      reset = 1'b1;
      @(negedge sys_clk);
      check(frame_trig_overruns, 16'h0000);
      check(burst_trig_overruns, 16'h0000);
      check(expo_end_overruns, 16'h0000);
      check(exposing, 1'b0);
      reset = 1'b0;
      repeat (3) @(negedge sys_clk);
      check(acquiring, 1'b0);
      check(burst_trig_ready, 1'b1);
      stop_test();
   end
endmodule : frame_metadata_stamper_tb_top
